// >>> design/amp_prot_pkg.sv
// Shared constants and types for the amplifier protection monitor.
// Assumes a 50 MHz ref_clk and a register port driven by a bus engine.
package amp_prot_pkg;
  localparam int          NUM_CH          = 4;
  localparam int          CLK_MHZ         = 50;
  // Overcurrent shutdown window, in microseconds
  localparam int          OC_MIN_US       = 200;
  localparam int          OC_MAX_US       = 390;
  // Both ends scale exactly to cycles; shutdown sits at their midpoint
  localparam int          OC_MIN_CYC      = OC_MIN_US * CLK_MHZ;
  localparam int          OC_MAX_CYC      = OC_MAX_US * CLK_MHZ;
  localparam int          OC_SHUT_CYC     = (OC_MIN_CYC + OC_MAX_CYC) / 2;
  localparam int          OC_CNT_W        = 15;
  localparam int          TEMP_HYST_C     = 10;
  localparam int          DC_CNT_W        = 16;
  // Register offsets
  localparam logic [7:0]  REG_FAULT       = 8'h00;
  localparam logic [7:0]  REG_SUPPLY      = 8'h01;
  localparam logic [7:0]  REG_DCFAULT     = 8'h02;
  localparam logic [7:0]  REG_TEMP        = 8'h04;
  localparam logic [7:0]  REG_WARNCFG     = 8'h0a;
  localparam logic [7:0]  REG_DCLEVEL     = 8'h0b;
  localparam logic [7:0]  REG_PLAY        = 8'h0c;
  localparam logic [7:0]  REG_DCTIME      = 8'h0d;
  localparam logic [7:0]  REG_CLEAR       = 8'h0e;
  // Field positions
  localparam int          TW_BIT0         = 5;
  localparam int          TSD_BIT         = 4;
  localparam int          UV_PS_BIT       = 0;
  localparam int          UV_AN_BIT       = 1;
  localparam int          UV_CP_BIT       = 2;
  localparam int          OV_BIT          = 3;
  localparam int          DCSD_EN_BIT     = 2;
  // Reset values
  localparam logic [1:0]  WARN_MODE_RST   = 2'h1;
  localparam logic        DCSD_EN_RST     = 1'b0;
  localparam logic [7:0]  DC_LEVEL_RST    = 8'h40;
  localparam logic [7:0]  DC_TIME_RST     = 8'h10;
  localparam int          DC_TIME_SHIFT   = 8;

  typedef enum logic [1:0] {
    WARN_CLIP  = 2'h0,
    WARN_TEMP  = 2'h1,
    WARN_BOTH  = 2'h2,
    WARN_TWEET = 2'h3
  } warn_mode_type;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [NUM_CH-1:0] avgOver;
    logic [NUM_CH-1:0] peakOver;
    logic [NUM_CH-1:0] severe;
    logic [NUM_CH-1:0] fullDuty;
    logic [NUM_CH-1:0] tweetHit;
  } ch_sense_type;

  typedef struct packed {
    logic uvPower;
    logic uvAnalog;
    logic uvPump;
    logic ovPower;
    logic porLow;
  } supply_sense_type;
endpackage

// >>> design/sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,  // Clock
  input  wire logic         reset,    // Sync reset, high
  input  wire logic [W-1:0] din,      // Async input
  output logic      [W-1:0] dout      // Filtered output
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [W-1:0] nxt_out;

  always_comb begin
    nxt_out = out_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_out[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end else begin
      s1_ff  <= din;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign dout = out_ff;
endmodule
`default_nettype wire

// >>> design/amp_protection_fault_monitor.sv
// Protection and fault monitor for a four-channel class-D amplifier.
// Assumes analog comparators on async inputs and a byte register port
// fed by an external serial bus engine.
// Functional notes
// - Average overcurrent trims the pulse; channels keep playing.
// - Severe peak short shuts its channel within 200 to 390 us.
// - Overcurrent shutdown sets fault pin and per-channel status bit.
// - Non-severe peak overcurrent limits only; recovers by itself.
// - DC detect fires when offset holds at level for programmed time.
// - DC shutdown option is off after reset; software can toggle it.
// - Enabled DC shutdown stops the triggered channel and sets fault.
// - Clip indication follows any channel at full duty cycle.
// - Warning pin source: clip, temperature, both, or tweeter detect.
// - Warning pin reports temperature warning after reset.
// - Temperature mode asserts the pin at the first warning level.
// - Three thresholds, each releasing 10 C below its set point.
// - Threshold flags live in bits 5 to 7 of temperature_warning_status.
// - Overtemperature shutdown floats all outputs and sets fault.
// - Register port stays alive during overtemperature shutdown.
// - First warning stays until temperature drops 10 C below level one.
// - Thermal foldback lowers channel gain at high temperature.
// - Undervoltage sets fault and the bit of the causing supply.
// - Power-on reset floats the bus; host must reprogram after.
// - Overvoltage sets fault and its status bit.
// - Faults move outputs straight to high impedance, no ramp.
// - Host clears latched faults and returns channels to play.
`timescale 1ns/1ps
`default_nettype none
module amp_protection_fault_monitor (
  input  wire logic                          ref_clk,     // 50 MHz clock
  input  wire logic                          reset,       // Sync reset, high
  input  wire amp_prot_pkg::reg_req_type     regReq,      // Register access
  output logic [7:0]                         regRdata,    // Read data
  output logic                               regAck,      // Access done
  input  wire amp_prot_pkg::ch_sense_type    chSense,     // Channel sense
  input  wire amp_prot_pkg::supply_sense_type supSense,   // Supply sense
  input  wire logic [7:0]                    dcOffset,    // Offset magnitude
  input  wire logic                          dcChValid,   // Offset sample strobe
  input  wire logic [1:0]                    dcCh,        // Offset channel
  input  wire logic [7:0]                    dieTemp,     // Die temp, deg C
  input  wire logic [7:0]                    twLevel1,    // Warning level 1
  input  wire logic [7:0]                    twLevel2,    // Warning level 2
  input  wire logic [7:0]                    twLevel3,    // Warning level 3
  input  wire logic [7:0]                    tsdLevel,    // Shutdown level
  output logic [3:0]                         pulseCut,    // Cut PWM pulse
  output logic [3:0]                         chPlay,      // Channel switching
  output logic [3:0]                         chHiZ,       // Channel floated
  output logic                               gainFold,    // Gain foldback
  output logic                               faultN,      // Fault pin, low
  output logic                               warnN,       // Warning pin, low
  output logic                               busRelease,  // Float bus pins
  output logic                               porSeen      // Needs reprogram
);
  localparam int NC = amp_prot_pkg::NUM_CH;

  // Async comparators all pass the three-stage filter
  localparam int SW = 5 * NC + 5;
  logic [SW-1:0] senseRaw, senseSync;
  amp_prot_pkg::ch_sense_type     chS;
  amp_prot_pkg::supply_sense_type supS;

  assign senseRaw = {chSense, supSense};

  sync3 #(.W(SW)) uSync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .din     (senseRaw),
    .dout    (senseSync)
  );

  assign chS  = senseSync[SW-1:5];
  assign supS = senseSync[4:0];

  // Hysteresis compare used for each temperature warning threshold
  function automatic logic hyst(input logic prev, input logic [7:0] t,
                                input logic [7:0] lvl);
    logic [8:0] rel;
    rel = {1'b0, lvl} - 9'(amp_prot_pkg::TEMP_HYST_C);
    if (t >= lvl) begin
      hyst = 1'b1;
    end else if (rel[8] || ({1'b0, t} < rel)) begin
      hyst = 1'b0;
    end else begin
      hyst = prev;
    end
  endfunction

  // State
  logic [3:0]                  ocFault_ff, nxt_ocFault;
  logic [3:0]                  dcFault_ff, nxt_dcFault;
  logic [3:0]                  dcTrip_ff, nxt_dcTrip;
  logic [3:0]                  play_ff, nxt_play;
  logic [4:0]                  supFault_ff, nxt_supFault;
  logic [2:0]                  tw_ff, nxt_tw;
  logic                        tsdOn_ff, nxt_tsdOn;
  logic                        porSeen_ff, nxt_porSeen;
  amp_prot_pkg::warn_mode_type mode_ff, nxt_mode;
  logic                        dcsdEn_ff, nxt_dcsdEn;
  logic [7:0]                  dcLevel_ff, nxt_dcLevel;
  logic [7:0]                  dcTime_ff, nxt_dcTime;
  logic [7:0]                  rdata_ff, nxt_rdata;
  logic                        ack_ff, nxt_ack;
  logic [amp_prot_pkg::OC_CNT_W-1:0] ocCnt_ff [NC];
  logic [amp_prot_pkg::OC_CNT_W-1:0] nxt_ocCnt [NC];
  logic [amp_prot_pkg::DC_CNT_W-1:0] dcCnt_ff [NC];
  logic [amp_prot_pkg::DC_CNT_W-1:0] nxt_dcCnt [NC];
  logic [7:0]                  outFlags_ff, nxt_outFlags;

  logic                        wrHit, anyLatched, clipAny, tempWarn;
  logic [amp_prot_pkg::DC_CNT_W-1:0] dcLimit;

  assign wrHit    = regReq.wrEn;
  assign clipAny  = |chS.fullDuty;
  assign tempWarn = tw_ff[0];
  assign dcLimit  = amp_prot_pkg::DC_CNT_W'({dcTime_ff,
                    amp_prot_pkg::DC_TIME_SHIFT'(0)});
  assign anyLatched = (|ocFault_ff) || (|dcFault_ff) || (|supFault_ff[3:0])
                      || tsdOn_ff;

  // Protection state
  always_comb begin
    nxt_ocFault  = ocFault_ff;
    nxt_dcFault  = dcFault_ff;
    nxt_dcTrip   = dcTrip_ff;
    nxt_play     = play_ff;
    nxt_supFault = supFault_ff;
    nxt_tw       = tw_ff;
    nxt_tsdOn    = tsdOn_ff;
    nxt_porSeen  = porSeen_ff;
    nxt_ocCnt    = ocCnt_ff;
    nxt_dcCnt    = dcCnt_ff;

    // Software clears first, so a same-cycle event below still wins
    if (wrHit && regReq.addr == amp_prot_pkg::REG_CLEAR) begin
      nxt_ocFault  = ocFault_ff & ~regReq.wdata[3:0];
      nxt_dcFault  = dcFault_ff & ~regReq.wdata[3:0];
      nxt_dcTrip   = dcTrip_ff & ~regReq.wdata[3:0];
      if (regReq.wdata[7]) begin
        nxt_supFault = 5'h00;
        nxt_tsdOn    = 1'b0;
        nxt_porSeen  = 1'b0;
      end
    end
    if (wrHit && regReq.addr == amp_prot_pkg::REG_PLAY) begin
      nxt_play = regReq.wdata[3:0];
    end

    for (int c = 0; c < NC; c++) begin
      // Only a persistent severe short counts; plain peak limit recovers
      if (chS.severe[c] && play_ff[c]) begin
        if (ocCnt_ff[c] >= amp_prot_pkg::OC_CNT_W'(
              amp_prot_pkg::OC_SHUT_CYC - 1)) begin
          nxt_ocFault[c] = 1'b1;
          nxt_play[c]    = 1'b0;
          nxt_ocCnt[c]   = '0;
        end else begin
          nxt_ocCnt[c] = ocCnt_ff[c] + 1'b1;
        end
      end else begin
        nxt_ocCnt[c] = '0;
      end
      if (dcChValid && dcCh == 2'(c)) begin
        if (dcOffset >= dcLevel_ff && play_ff[c]) begin
          if (dcCnt_ff[c] >= dcLimit) begin
            nxt_dcTrip[c] = 1'b1;
            if (dcsdEn_ff) begin
              nxt_dcFault[c] = 1'b1;
              nxt_play[c]    = 1'b0;
            end
          end else begin
            nxt_dcCnt[c] = dcCnt_ff[c] + 1'b1;
          end
        end else begin
          nxt_dcCnt[c] = '0;
        end
      end
    end

    nxt_tw[0] = hyst(tw_ff[0], dieTemp, twLevel1);
    nxt_tw[1] = hyst(tw_ff[1], dieTemp, twLevel2);
    nxt_tw[2] = hyst(tw_ff[2], dieTemp, twLevel3);

    if (dieTemp >= tsdLevel) begin
      nxt_tsdOn = 1'b1;
      nxt_play  = 4'h0;
    end
    if (supS.uvPower) begin
      nxt_supFault[amp_prot_pkg::UV_PS_BIT] = 1'b1;
    end
    if (supS.uvAnalog) begin
      nxt_supFault[amp_prot_pkg::UV_AN_BIT] = 1'b1;
    end
    if (supS.uvPump) begin
      nxt_supFault[amp_prot_pkg::UV_CP_BIT] = 1'b1;
    end
    if (supS.ovPower) begin
      nxt_supFault[amp_prot_pkg::OV_BIT] = 1'b1;
    end
    if (supS.uvPower || supS.uvAnalog || supS.uvPump || supS.ovPower) begin
      nxt_play = 4'h0;
    end
    if (supS.porLow) begin
      nxt_porSeen = 1'b1;
      nxt_play    = 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ocFault_ff  <= 4'h0;
      dcFault_ff  <= 4'h0;
      dcTrip_ff   <= 4'h0;
      play_ff     <= 4'h0;
      supFault_ff <= 5'h00;
      tw_ff       <= 3'h0;
      tsdOn_ff    <= 1'b0;
      porSeen_ff  <= 1'b0;
      for (int c = 0; c < NC; c++) begin
        ocCnt_ff[c] <= '0;
        dcCnt_ff[c] <= '0;
      end
    end else begin
      ocFault_ff  <= nxt_ocFault;
      dcFault_ff  <= nxt_dcFault;
      dcTrip_ff   <= nxt_dcTrip;
      play_ff     <= nxt_play;
      supFault_ff <= nxt_supFault;
      tw_ff       <= nxt_tw;
      tsdOn_ff    <= nxt_tsdOn;
      porSeen_ff  <= nxt_porSeen;
      ocCnt_ff    <= nxt_ocCnt;
      dcCnt_ff    <= nxt_dcCnt;
    end
  end

  // Register port; served by logic clocked here, so it stays up in shutdown
  always_comb begin
    nxt_mode    = mode_ff;
    nxt_dcsdEn  = dcsdEn_ff;
    nxt_dcLevel = dcLevel_ff;
    nxt_dcTime  = dcTime_ff;
    nxt_rdata   = rdata_ff;
    nxt_ack     = regReq.wrEn || regReq.rdEn;
    if (wrHit) begin
      case (regReq.addr)
        amp_prot_pkg::REG_WARNCFG: begin
          nxt_mode   = amp_prot_pkg::warn_mode_type'(regReq.wdata[1:0]);
          nxt_dcsdEn = regReq.wdata[amp_prot_pkg::DCSD_EN_BIT];
        end
        amp_prot_pkg::REG_DCLEVEL: nxt_dcLevel = regReq.wdata;
        amp_prot_pkg::REG_DCTIME:  nxt_dcTime  = regReq.wdata;
        default: ;
      endcase
    end
    if (regReq.rdEn) begin
      case (regReq.addr)
        amp_prot_pkg::REG_FAULT:   nxt_rdata = {dcFault_ff, ocFault_ff};
        amp_prot_pkg::REG_SUPPLY:  nxt_rdata = {2'h0, porSeen_ff,
                                                supFault_ff};
        amp_prot_pkg::REG_DCFAULT: nxt_rdata = {4'h0, dcTrip_ff};
        amp_prot_pkg::REG_TEMP:    nxt_rdata = {tw_ff, tsdOn_ff,
                                                4'h0};
        amp_prot_pkg::REG_WARNCFG: nxt_rdata = {5'h00, dcsdEn_ff, mode_ff};
        amp_prot_pkg::REG_DCLEVEL: nxt_rdata = dcLevel_ff;
        amp_prot_pkg::REG_PLAY:    nxt_rdata = {4'h0, play_ff};
        amp_prot_pkg::REG_DCTIME:  nxt_rdata = dcTime_ff;
        default:                   nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_ff    <= amp_prot_pkg::warn_mode_type'(
                    amp_prot_pkg::WARN_MODE_RST);
      dcsdEn_ff  <= amp_prot_pkg::DCSD_EN_RST;
      dcLevel_ff <= amp_prot_pkg::DC_LEVEL_RST;
      dcTime_ff  <= amp_prot_pkg::DC_TIME_RST;
      rdata_ff   <= 8'h00;
      ack_ff     <= 1'b0;
    end else begin
      mode_ff    <= nxt_mode;
      dcsdEn_ff  <= nxt_dcsdEn;
      dcLevel_ff <= nxt_dcLevel;
      dcTime_ff  <= nxt_dcTime;
      rdata_ff   <= nxt_rdata;
      ack_ff     <= nxt_ack;
    end
  end

  // Pin outputs, registered
  always_comb begin
    logic warn;
    warn = 1'b0;
    case (mode_ff)
      amp_prot_pkg::WARN_CLIP:  warn = clipAny;
      amp_prot_pkg::WARN_TEMP:  warn = tempWarn;
      amp_prot_pkg::WARN_BOTH:  warn = clipAny || tempWarn;
      amp_prot_pkg::WARN_TWEET: warn = |chS.tweetHit;
      default:                  warn = 1'b0;
    endcase
    nxt_outFlags = {2'h0, supS.porLow, tw_ff[1], anyLatched, warn, 2'h0};
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      outFlags_ff <= 8'h00;
    end else begin
      outFlags_ff <= nxt_outFlags;
    end
  end

  assign pulseCut   = chS.avgOver | chS.peakOver;
  assign chPlay     = play_ff;
  assign chHiZ      = ~play_ff;
  assign gainFold   = outFlags_ff[4];
  assign faultN     = ~outFlags_ff[3];
  assign warnN      = ~outFlags_ff[2];
  assign busRelease = outFlags_ff[5];
  assign porSeen    = porSeen_ff;
  assign regRdata   = rdata_ff;
  assign regAck     = ack_ff;
endmodule
`default_nettype wire

// >>> verif/amp_prot_chk.sv
// Port-level assertions for the amplifier protection monitor.
// Assumes one clock domain with the sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
module amp_prot_chk (
  input wire logic                           ref_clk,    // Clock
  input wire logic                           reset,      // Sync reset
  input wire amp_prot_pkg::reg_req_type      regReq,     // Request
  input wire logic [7:0]                     regRdata,   // Read data
  input wire logic                           regAck,     // Acknowledge
  input wire amp_prot_pkg::ch_sense_type     chSense,    // Channel sense
  input wire amp_prot_pkg::supply_sense_type supSense,   // Supply sense
  input wire logic [7:0]                     dieTemp,    // Die temp
  input wire logic [7:0]                     tsdLevel,   // Shutdown level
  input wire logic [3:0]                     pulseCut,   // Pulse cut
  input wire logic [3:0]                     chPlay,     // Play bits
  input wire logic [3:0]                     chHiZ,      // Float bits
  input wire logic                           faultN,     // Fault pin
  input wire logic                           busRelease  // Bus floated
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic clrWr;
  assign clrWr = regReq.wrEn && regReq.addr == amp_prot_pkg::REG_CLEAR;

  a_ack_follows: assert property (
    regReq.rdEn || regReq.wrEn |=> regAck) else $error("missing ack");
  a_unmapped_zero: assert property (
    regReq.rdEn && regReq.addr > 8'h0e |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_float_tracks: assert property (chHiZ == ~chPlay)
    else $error("float bits disagree with play bits");
  a_avg_cut: assert property (
    chSense.avgOver[1] [*6] |-> pulseCut[1])
    else $error("average overcurrent not cut");
  a_por_quiet: assert property (busRelease |-> chPlay == 4'h0)
    else $error("channels playing while bus released");
  a_cut_recovers: assert property (
    (!chSense.avgOver[0] && !chSense.peakOver[0]) [*6] |-> !pulseCut[0])
    else $error("pulse cut did not release");
  a_tsd_float: assert property (
    (dieTemp >= tsdLevel) [*8] |-> chPlay == 4'h0 && !faultN)
    else $error("shutdown temperature left outputs on");
  a_supply_fault: assert property (
    (supSense.uvAnalog || supSense.ovPower) [*8] |-> !faultN)
    else $error("supply fault not flagged");
  a_bus_float: assert property (
    $stable(supSense.porLow) [*8] |-> busRelease == supSense.porLow)
    else $error("bus release wrong");
  a_fault_holds: assert property (
    !faultN && !clrWr && !$past(clrWr) && !$past(clrWr, 2) |=> !faultN)
    else $error("fault pin released without clear");
endmodule

bind amp_protection_fault_monitor amp_prot_chk chk_u (
  .ref_clk(ref_clk), .reset(reset), .regReq(regReq), .regRdata(regRdata),
  .regAck(regAck), .chSense(chSense), .supSense(supSense),
  .dieTemp(dieTemp), .tsdLevel(tsdLevel), .pulseCut(pulseCut),
  .chPlay(chPlay), .chHiZ(chHiZ), .faultN(faultN), .busRelease(busRelease)
);
`default_nettype wire

// >>> verif/amp_host_model.sv
// Host controller model on the monitor's byte register port.
// Assumes one-cycle request pulses and a registered acknowledge.
`timescale 1ns/1ps
`default_nettype none
module amp_host_model (
  input  wire logic                     ref_clk,  // Clock
  output var amp_prot_pkg::reg_req_type regReq,   // Request pulse
  input  wire logic [7:0]               regRdata, // Read data
  input  wire logic                     regAck,   // Acknowledge
  output var logic                      hung      // Ack never came
);
  initial begin
    regReq = '0;
    hung = 1'b0;
  end
  // Idle address and data show the inverse, so stale values never match
  task automatic xfer(input logic wr, input logic [7:0] a, d,
                      output logic [7:0] q);
    logic got;
    got = 1'b0;
    q = 8'h00;
    @(posedge ref_clk);
    regReq <= '{wrEn: wr, rdEn: !wr, addr: a, wdata: d};
    @(posedge ref_clk);
    regReq <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
    for (int n = 0; n < 8 && !got; n++) begin
      @(posedge ref_clk);
      got = regAck;
      q = regRdata;
    end
    if (!got)
      hung <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  // Recovery: drop latched faults first, then replay channels
  task automatic restart(input logic [7:0] clr, play);
    wr(amp_prot_pkg::REG_CLEAR, clr);
    wr(amp_prot_pkg::REG_PLAY, play);
  endtask
endmodule
`default_nettype wire

// >>> verif/amp_protection_fault_monitor_tb_top.sv
// Self-checking bench for the amplifier protection monitor.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module amp_protection_fault_monitor_tb_top;
  logic ref_clk, reset, regAck, gainFold, faultN, warnN, hung;
  logic busRelease, porSeen, dcChValid;
  logic [7:0] regRdata, dcOffset, dieTemp, tsdLevel;
  logic [3:0] pulseCut, chPlay, chHiZ;
  logic [1:0] dcCh;
  amp_prot_pkg::reg_req_type      regReq;
  amp_prot_pkg::ch_sense_type     chSense;
  amp_prot_pkg::supply_sense_type supSense;
  int num_errors, checked, n;

  amp_protection_fault_monitor dut_u (.ref_clk(ref_clk), .reset(reset),
    .regReq(regReq), .regRdata(regRdata), .regAck(regAck),
    .chSense(chSense), .supSense(supSense), .dcOffset(dcOffset),
    .dcChValid(dcChValid), .dcCh(dcCh), .dieTemp(dieTemp),
    .twLevel1(8'h64), .twLevel2(8'h6e), .twLevel3(8'h78),
    .tsdLevel(tsdLevel), .pulseCut(pulseCut), .chPlay(chPlay),
    .chHiZ(chHiZ), .gainFold(gainFold), .faultN(faultN), .warnN(warnN),
    .busRelease(busRelease), .porSeen(porSeen));
  amp_host_model host_u (.ref_clk(ref_clk), .regReq(regReq),
    .regRdata(regRdata), .regAck(regAck), .hung(hung));

  task automatic chk(input logic [15:0] seen, exp, input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, exp, input string what);
    logic [7:0] q;
    host_u.xfer(1'b0, a, 8'h00, q);
    chk(q, exp, what);
  endtask
  // Sense inputs pass a four-cycle filter; eight gives margin
  task automatic settle();
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic dc_run();
    // One low sample first, so no count is left from an earlier run
    dcCh <= 2'h1;
    dcOffset <= 8'h00;
    dcChValid <= 1'b1;
    @(posedge ref_clk);
    dcOffset <= 8'h50;
    repeat (200) @(posedge ref_clk);
    chk(chPlay, 4'hf, "dc not yet");
    repeat (100) @(posedge ref_clk);
    dcChValid <= 1'b0;
    settle();
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge hung) begin
    num_errors++;
    end_of_test();
  end
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    {reset, dcChValid, dcCh, dcOffset, chSense, supSense} = '1;
    chSense = '0;
    supSense = '0;
    dcOffset = 8'h00;
    dcChValid = 1'b0;
    dcCh = 2'h0;
    dieTemp = 8'h19;
    tsdLevel = 8'h8c;
    num_errors = 0;
    checked = 0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk(faultN, 1'b1, "fault idle");
    chk(chHiZ, 4'hf, "outputs float");
    rd(8'h0a, 8'h01, "config reset");
    rd(8'h30, 8'h00, "unmapped read");
    host_u.wr(8'h0c, 8'h0f);
    settle();
    chk(chPlay, 4'hf, "all playing");
    for (n = 0; n < 4; n++) begin
      host_u.wr(8'h0a, n[7:0]);
      chSense.fullDuty <= 4'h4;
      settle();
      chk(warnN, n == 1 || n == 3, "clip source");
      chSense.fullDuty <= 4'h0;
      chSense.tweetHit <= 4'h2;
      settle();
      chk(warnN, n != 3, "tweeter source");
      chSense.tweetHit <= 4'h0;
      settle();
      chk(warnN, 1'b1, "warn idle");
    end
    $display("test warning modes done");
    host_u.wr(8'h0a, 8'h01);
    chSense.avgOver <= 4'h2;
    chSense.peakOver <= 4'h1;
    settle();
    chk(pulseCut, 4'h3, "pulse cut");
    chk(chPlay, 4'hf, "still playing");
    chSense.avgOver <= 4'h0;
    chSense.peakOver <= 4'h0;
    settle();
    chk(pulseCut, 4'h0, "cut released");
    rd(8'h00, 8'h00, "no latch");
    dieTemp <= 8'h69;
    settle();
    chk(warnN, 1'b0, "level one pin");
    rd(8'h04, 8'h20, "level one flag");
    dieTemp <= 8'h73;
    settle();
    chk(gainFold, 1'b1, "foldback");
    rd(8'h04, 8'h60, "level two flag");
    dieTemp <= 8'h7d;
    settle();
    rd(8'h04, 8'he0, "level three flag");
    dieTemp <= 8'h5f;
    settle();
    rd(8'h04, 8'h20, "hysteresis");
    chk(warnN, 1'b0, "pin held");
    dieTemp <= 8'h59;
    settle();
    rd(8'h04, 8'h00, "all released");
    chk(warnN, 1'b1, "pin released");
    dieTemp <= 8'h91;
    settle();
    chk(chPlay, 4'h0, "shutdown stops all");
    chk(faultN, 1'b0, "shutdown fault");
    rd(8'h04, 8'hf0, "shutdown flags");
    dieTemp <= 8'h19;
    settle();
    chk(chPlay, 4'h0, "no self resume");
    host_u.restart(8'h80, 8'h0f);
    settle();
    chk({faultN, chPlay}, 5'h1f, "recovered");
    $display("test temperature done");
    for (n = 0; n < 4; n++) begin
      supSense <= 5'h10 >> n;
      settle();
      chk(faultN, 1'b0, "supply fault");
      rd(8'h01, 8'h01 << n, "supply flag");
      supSense <= '0;
      // Filtered sense must drop first, else the set beats the clear
      settle();
      host_u.restart(8'h80, 8'h0f);
      settle();
      chk(faultN, 1'b1, "supply cleared");
    end
    supSense.porLow <= 1'b1;
    settle();
    chk(busRelease, 1'b1, "bus floated");
    supSense.porLow <= 1'b0;
    settle();
    chk({busRelease, porSeen}, 2'h1, "bus back");
    host_u.restart(8'h80, 8'h0f);
    host_u.wr(8'h0a, 8'h01);
    $display("test supplies done");
    host_u.wr(8'h0d, 8'h01);
    dc_run();
    rd(8'h02, 8'h02, "dc trip");
    chk(chPlay, 4'hf, "dc keeps playing");
    host_u.restart(8'h02, 8'h0f);
    host_u.wr(8'h0a, 8'h05);
    dc_run();
    chk(chPlay, 4'hd, "dc stops one");
    chk(faultN, 1'b0, "dc fault");
    host_u.restart(8'h02, 8'h0f);
    $display("test dc done");
    chSense.peakOver <= 4'h8;
    chSense.severe <= 4'h8;
    for (n = 0; n < 20000 && chPlay[3] === 1'b1; n++)
      @(posedge ref_clk);
    chk(n >= 10000 && n <= 19500, 1'b1, "short delay");
    if (n >= 20000)
      end_of_test();
    chk(chPlay, 4'h7, "only shorted stops");
    chSense <= '0;
    settle();
    chk(faultN, 1'b0, "short fault");
    rd(8'h00, 8'h08, "short flag");
    host_u.restart(8'h08, 8'h0f);
    settle();
    chk({faultN, chPlay}, 5'h1f, "short restart");
    $display("test short done");
    end_of_test();
  end
endmodule
`default_nettype wire
